// ### rtl/osf_pkg.sv
/*
  Shared constants for the one-time-programmable sector and parameter-read
  logic of a serial flash, and for the serial host that drives it.
  Assumes a single 250 MHz system clock on both ends.
*/
package osf_pkg;
  // System clock rate
  localparam int unsigned CLK_MHZ  = 250;
  // Serial clock period that the host makes, and least select-high time
  localparam int unsigned SCLK_NS  = 128;
  localparam int unsigned GAP_NS   = 15;
  localparam int unsigned HALF_CYC = (SCLK_NS * CLK_MHZ) / 2000;
  localparam int unsigned GAP_CYC  = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [4:0]  HALF_CNT = 5'(HALF_CYC - 1);
  localparam logic [4:0]  GAP_CNT  = 5'(GAP_CYC);

  // Opcodes
  localparam logic [7:0] OP_WRITE_STATUS_COMMAND  = 8'h01;
  localparam logic [7:0] OP_PROG  = 8'h02;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRITE_DISABLE_COMMAND  = 8'h04;
  localparam logic [7:0] OP_READ_STATUS_COMMAND  = 8'h05;
  localparam logic [7:0] OP_SE4K  = 8'h20;
  localparam logic [7:0] OP_OTP   = 8'h3A;
  localparam logic [7:0] OP_SFDP  = 8'h5A;
  localparam logic [7:0] OP_CE    = 8'hC7;
  localparam logic [7:0] OP_BE64K = 8'hD8;
  localparam logic [7:0] OP_NONE  = 8'hFF;

  // Status byte fields
  localparam int unsigned ST_BUSY  = 0;
  localparam int unsigned ST_BP_LO = 2;
  localparam int unsigned ST_BP_HI = 5;
  localparam int unsigned ST_PROT  = 7;

  // Bit positions within a frame
  localparam logic [5:0] BITS_CMD = 6'd8;
  localparam logic [5:0] BITS_WR  = 6'd16;
  localparam logic [5:0] BITS_A3  = 6'd32;
  localparam logic [5:0] BITS_A4  = 6'd40;
  localparam logic [5:0] BITS_DUM = 6'd8;
  localparam logic [5:0] CNT_HI   = 6'd63;
  localparam logic [5:0] CNT_LO   = 6'd56;

  // Discoverable-parameter contents
  localparam logic [31:0] SFDP_SIG   = 32'h5044_4653;
  localparam logic [7:0]  SFDP_MIN   = 8'h00;
  localparam logic [7:0]  SFDP_MAJ   = 8'h01;
  localparam logic [7:0]  SFDP_NPH   = 8'h00;
  localparam logic [7:0]  PT_LEN     = 8'h09;
  localparam logic [23:0] PT_PTR     = 24'h00_0030;
  localparam logic [31:0] PT_DENSITY = 32'h00FF_FFFF;

  typedef enum logic [1:0] {
    OK_PROG   = 2'd0,
    OK_SECTOR = 2'd1,
    OK_BLOCK  = 2'd2,
    OK_CHIP   = 2'd3
  } osf_op_type;
endpackage

// ### rtl/osf_spi_if.sv
/*
  Serial link between the flash end and the host end: select, clock,
  data in and data out with its enable.
  Assumes a pull-up on the data-out line while the flash releases it.
*/
`timescale 1ns/1ns
interface osf_spi_if;
  logic sel_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sdo_pin;

  assign sdo_pin = sdo_oe ? sdo : 1'b1;

  modport dev  (input sel_n, sclk, sdi, output sdo, sdo_oe);
  modport host (output sel_n, sclk, sdi, input sdo_pin);
endinterface

// ### rtl/osf_flash_host.sv
/*
  Serial host: runs one command frame at a time, opcode, address,
  dummy, optional write byte and a number of read bytes.
  Assumes the flash end samples on rising and drives on falling edges.
*/
`timescale 1ns/1ns
module osf_flash_host (
  input  logic        clock_i,
  input  logic        resetn_i,
  osf_spi_if.host     bus,
  input  logic        cmd_valid_i,
  output logic        cmd_ready_o,
  input  logic [7:0]  cmd_op_i,
  input  logic [31:0] cmd_addr_i,
  input  logic [2:0]  cmd_nad_i,
  input  logic        cmd_dummy_i,
  input  logic        cmd_wr_i,
  input  logic [7:0]  cmd_wdata_i,
  input  logic [7:0]  cmd_nrd_i,
  output logic        done_o,
  output logic        refused_o,
  output logic        rd_valid_o,
  output logic [7:0]  rd_data_o
);
  import osf_pkg::*;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_RUN  = 3'b010,
    HS_GAP  = 3'b100
  } osf_hstate_type;

  osf_hstate_type state_q;
  logic [4:0]     div_q;
  logic [1:0]     sdo_s_q;
  logic           sclk_q, sel_n_q, sdi_q;
  logic [7:0]     txb_q, rx_q, wd_q, nxt;
  logic [2:0]     b_q, nad_q;
  logic [8:0]     k_q, kn, tot_q, ntx_q;
  logic [31:0]    ash_q;
  logic           dum_q, wr_q, bpc_q, otph_q, tick, gap_done, start, refuse;

  assign tick     = (state_q == HS_RUN) && (div_q == HALF_CNT);
  assign gap_done = (state_q == HS_GAP) && (div_q == GAP_CNT);
  assign cmd_ready_o = (state_q == HS_IDLE);
  assign refuse = cmd_ready_o && cmd_valid_i && (cmd_op_i == OP_OTP) && !bpc_q && !otph_q;
  assign start  = cmd_ready_o && cmd_valid_i && !refuse;
  assign kn     = k_q + 9'd1;
  assign bus.sel_n = sel_n_q;
  assign bus.sclk  = sclk_q;
  assign bus.sdi   = sdi_q;

  always_comb begin
    nxt = 8'hFF;
    if (kn <= 9'(nad_q)) begin
      nxt = ash_q[31:24];
    end else if (dum_q && kn == 9'(nad_q) + 9'd1) begin
      nxt = 8'h00;
    end else if (wr_q && kn == ntx_q - 9'd1) begin
      nxt = wd_q;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sdo_s_q <= 2'b11;
    end else begin
      sdo_s_q <= {sdo_s_q[0], bus.sdo_pin};
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q <= 5'd0;
    end else if (state_q == HS_IDLE || tick || gap_done) begin
      div_q <= 5'd0;
    end else begin
      div_q <= div_q + 5'd1;
    end
  end

  // Tracks protect bits and mode as last written by this host
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bpc_q  <= 1'b1;
      otph_q <= 1'b0;
    end else if (start) begin
      if (cmd_op_i == OP_WRITE_STATUS_COMMAND && !otph_q) begin
        bpc_q <= (cmd_wdata_i[ST_BP_HI:ST_BP_LO] == 4'h0);
      end
      if (cmd_op_i == OP_OTP) begin
        otph_q <= 1'b1;
      end else if (cmd_op_i == OP_WRITE_DISABLE_COMMAND) begin
        otph_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q    <= HS_IDLE;
      sel_n_q    <= 1'b1;
      sclk_q     <= 1'b0;
      sdi_q      <= 1'b0;
      txb_q      <= 8'h00;
      rx_q       <= 8'h00;
      b_q        <= 3'd0;
      k_q        <= 9'd0;
      tot_q      <= 9'd0;
      ntx_q      <= 9'd0;
      ash_q      <= 32'h0000_0000;
      nad_q      <= 3'd0;
      dum_q      <= 1'b0;
      wr_q       <= 1'b0;
      wd_q       <= 8'h00;
      done_o     <= 1'b0;
      refused_o  <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o  <= 8'h00;
    end else begin
      done_o     <= refuse;
      refused_o  <= refuse;
      rd_valid_o <= 1'b0;
      unique case (state_q)
        HS_IDLE: begin
          if (start) begin
            state_q <= HS_RUN;
            sel_n_q <= 1'b0;
            sdi_q   <= cmd_op_i[7];
            txb_q   <= {cmd_op_i[6:0], 1'b0};
            b_q     <= 3'd0;
            k_q     <= 9'd0;
            nad_q   <= cmd_nad_i;
            dum_q   <= cmd_dummy_i;
            wr_q    <= cmd_wr_i;
            wd_q    <= cmd_wdata_i;
            ash_q   <= (cmd_nad_i == 3'd4) ? cmd_addr_i : {cmd_addr_i[23:0], 8'h00};
            ntx_q   <= 9'd1 + 9'(cmd_nad_i) + 9'(cmd_dummy_i) + 9'(cmd_wr_i);
            tot_q   <= 9'd1 + 9'(cmd_nad_i) + 9'(cmd_dummy_i) + 9'(cmd_wr_i)
                       + 9'(cmd_nrd_i);
          end
        end
        HS_RUN: begin
          if (tick && !sclk_q) begin
            sclk_q <= 1'b1;
            rx_q   <= {rx_q[6:0], sdo_s_q[1]};
          end else if (tick) begin
            sclk_q <= 1'b0;
            b_q    <= b_q + 3'd1;
            if (b_q == 3'd7) begin
              k_q <= kn;
              if (k_q >= ntx_q) begin
                rd_valid_o <= 1'b1;
                rd_data_o  <= rx_q;
              end
              if (kn == tot_q) begin
                state_q <= HS_GAP;
                sel_n_q <= 1'b1;
              end else begin
                sdi_q <= nxt[7];
                txb_q <= {nxt[6:0], 1'b0};
                if (kn <= 9'(nad_q)) begin
                  ash_q <= {ash_q[23:0], 8'h00};
                end
              end
            end else begin
              sdi_q <= txb_q[7];
              txb_q <= {txb_q[6:0], 1'b0};
            end
          end
        end
        HS_GAP: begin
          if (gap_done) begin
            state_q <= HS_IDLE;
            done_o  <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule // osf_flash_host

// ### rtl/osf_flash_dev.sv
/*
  Flash end: decodes serial frames for the one-time-programmable sector
  mode and the discoverable-parameter read, keeps protect and lock bits,
  and hands program, erase and read accesses to the storage beside it.
  Assumes storage answers rd_data_i for rd_addr_o within a few cycles,
  and that busy_i is high while a program, erase or status cycle runs.
*/
`timescale 1ns/1ns
module osf_flash_dev (
  input  logic                clock_i,
  input  logic                resetn_i,
  osf_spi_if.dev              bus,
  input  logic                addr4_i,
  input  logic                busy_i,
  input  logic [7:0]          rd_data_i,
  output logic [31:0]         rd_addr_o,
  output logic                rd_otp_o,
  output logic                otp_mode_o,
  output logic                otp_lock_o,
  output logic                op_valid_o,
  output osf_pkg::osf_op_type op_kind_o,
  output logic                op_otp_o,
  output logic [31:0]         op_addr_o,
  output logic [7:0]          op_data_o
);
  import osf_pkg::*;

  logic [2:0]  s1_q, s2_q;
  logic        sclk_d1_q, sel_d1_q;
  logic        in_frame, rise, fall, f_start, f_end, bit_in;
  logic [5:0]  cnt_q, addr_end, hdr_out;
  logic [6:0]  sr_q, sh_q;
  logic [7:0]  op_q, wd_q, byte_in, fetch, status;
  logic [31:0] addr_q, addr_m;
  logic [2:0]  ocnt_q;
  logic        rej_q, otp_q, lock_q, srp_q, sdo_q, oe_q;
  logic [3:0]  bp_q;
  logic        otp_ok, arr_ok, out_cmd, out_go, data_byte, is_erase, erase_ok;
  osf_op_type  kind;

  function automatic logic [7:0] sfdp_rom(input logic [7:0] a);
    unique case (a)
      8'h00: sfdp_rom = SFDP_SIG[7:0];
      8'h01: sfdp_rom = SFDP_SIG[15:8];
      8'h02: sfdp_rom = SFDP_SIG[23:16];
      8'h03: sfdp_rom = SFDP_SIG[31:24];
      8'h04: sfdp_rom = SFDP_MIN;
      8'h05: sfdp_rom = SFDP_MAJ;
      8'h06: sfdp_rom = SFDP_NPH;
      8'h08, 8'h09: sfdp_rom = 8'h00;
      8'h0A: sfdp_rom = SFDP_MAJ;
      8'h0B: sfdp_rom = PT_LEN;
      8'h0C: sfdp_rom = PT_PTR[7:0];
      8'h0D: sfdp_rom = PT_PTR[15:8];
      8'h0E: sfdp_rom = PT_PTR[23:16];
      8'h30: sfdp_rom = 8'hE5;
      8'h31, 8'h4D: sfdp_rom = OP_SE4K;
      8'h32: sfdp_rom = 8'hB3;
      8'h34: sfdp_rom = PT_DENSITY[7:0];
      8'h35: sfdp_rom = PT_DENSITY[15:8];
      8'h36: sfdp_rom = PT_DENSITY[23:16];
      8'h37: sfdp_rom = PT_DENSITY[31:24];
      // quad fast read dummies and modes
      8'h38, 8'h4A: sfdp_rom = 8'h44;
      8'h39, 8'h4B: sfdp_rom = 8'hEB;
      8'h3A, 8'h46, 8'h4E, 8'h52: sfdp_rom = 8'h00;
      8'h3C: sfdp_rom = 8'h08;
      8'h3D: sfdp_rom = 8'h3B;
      8'h3E: sfdp_rom = 8'h04;
      8'h3F: sfdp_rom = 8'hBB;
      8'h40: sfdp_rom = 8'hFE;
      8'h4C: sfdp_rom = 8'h0C;
      8'h50: sfdp_rom = 8'h10;
      8'h51: sfdp_rom = OP_BE64K;
      default: sfdp_rom = 8'hFF;
    endcase
  endfunction

  function automatic logic [31:0] bump(input logic [31:0] a, input logic sfdp,
                                       input logic otp);
    if (sfdp) begin
      bump = {24'h00_0000, a[7:0] + 8'h01};
    end else if (otp) begin
      bump = {23'h00_0000, a[8:0] + 9'h001};
    end else begin
      bump = a + 32'h0000_0001;
    end
  endfunction

  // Select, clock and data cross in through two flops each
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_q      <= 3'b100;
      s2_q      <= 3'b100;
      sclk_d1_q <= 1'b0;
      sel_d1_q  <= 1'b1;
    end else begin
      s1_q      <= {bus.sel_n, bus.sclk, bus.sdi};
      s2_q      <= s1_q;
      sclk_d1_q <= s2_q[1];
      sel_d1_q  <= s2_q[2];
    end
  end

  assign in_frame = ~s2_q[2];
  assign f_start  = in_frame & sel_d1_q;
  assign f_end    = ~in_frame & ~sel_d1_q;
  assign rise     = in_frame & s2_q[1] & ~sclk_d1_q;
  assign fall     = in_frame & ~s2_q[1] & sclk_d1_q;
  assign bit_in   = s2_q[0];
  assign byte_in  = {sr_q, bit_in};
  assign addr_end = addr4_i ? BITS_A4 : BITS_A3;
  assign addr_m   = otp_q ? {23'h00_0000, addr_q[8:0]} : addr_q;
  assign otp_ok   = ~lock_q & (bp_q == 4'h0) & ~busy_i;
  assign arr_ok   = ~otp_q & ~busy_i;
  assign data_byte = rise & (op_q == OP_PROG) & (cnt_q >= addr_end) & (cnt_q[2:0] == 3'd7);

  always_comb begin
    status = 8'h00;
    status[ST_BUSY] = busy_i;
    status[ST_BP_HI:ST_BP_LO] = bp_q;
    status[ST_PROT] = otp_q ? lock_q : srp_q;
  end

  always_comb begin
    hdr_out = BITS_CMD;
    fetch   = rd_data_i;
    out_cmd = 1'b0;
    unique case (op_q)
      OP_READ_STATUS_COMMAND: begin
        out_cmd = 1'b1;
        fetch   = status;
      end
      OP_READ: begin
        out_cmd = 1'b1;
        hdr_out = addr_end;
      end
      OP_SFDP: begin
        out_cmd = ~rej_q;
        hdr_out = addr_end + BITS_DUM;
        fetch   = sfdp_rom(addr_q[7:0]);
      end
      default: ;
    endcase
  end
  assign out_go = fall & out_cmd & (cnt_q >= hdr_out);

  always_comb begin
    kind     = OK_SECTOR;
    is_erase = 1'b0;
    unique case (op_q)
      OP_SE4K: is_erase = (cnt_q == addr_end);
      OP_BE64K: begin
        kind     = OK_BLOCK;
        is_erase = (cnt_q == addr_end);
      end
      OP_CE: begin
        kind     = OK_CHIP;
        is_erase = (cnt_q == BITS_CMD);
      end
      default: ;
    endcase
  end
  // only sector erase in OTP mode
  assign erase_ok = otp_q ? ((op_q == OP_SE4K) & otp_ok) : arr_ok;

  // Counter folds back to 56 so byte phase survives long frames
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q  <= 6'd0;
      sr_q   <= 7'h00;
      op_q   <= OP_NONE;
      wd_q   <= 8'h00;
      rej_q  <= 1'b0;
      addr_q <= 32'h0000_0000;
    end else if (f_start) begin
      cnt_q  <= 6'd0;
      op_q   <= OP_NONE;
      rej_q  <= 1'b0;
      addr_q <= 32'h0000_0000;
    end else if (rise) begin
      cnt_q <= (cnt_q == CNT_HI) ? CNT_LO : cnt_q + 6'd1;
      sr_q  <= byte_in[6:0];
      if (cnt_q == BITS_CMD - 6'd1) begin
        op_q  <= byte_in;
        rej_q <= busy_i;
      end
      if (cnt_q[2:0] == 3'd7) begin
        wd_q <= byte_in;
      end
      if (cnt_q >= BITS_CMD && cnt_q < addr_end) begin
        addr_q <= {addr_q[30:0], bit_in};
      end else if (data_byte) begin
        addr_q <= bump(addr_q, 1'b0, otp_q);
      end
    end else if (out_go && ocnt_q == 3'd0) begin
      addr_q <= bump(addr_q, op_q == OP_SFDP, otp_q);
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      oe_q   <= 1'b0;
      sdo_q  <= 1'b0;
      sh_q   <= 7'h00;
      ocnt_q <= 3'd0;
    end else if (!in_frame || f_start) begin
      oe_q   <= 1'b0;
      ocnt_q <= 3'd0;
    end else if (out_go) begin
      oe_q   <= 1'b1;
      ocnt_q <= ocnt_q + 3'd1;
      if (ocnt_q == 3'd0) begin
        {sdo_q, sh_q} <= fetch;
      end else begin
        {sdo_q, sh_q} <= {sh_q, 1'b0};
      end
    end
  end
  assign bus.sdo    = sdo_q;
  assign bus.sdo_oe = oe_q & in_frame;

  // Lock is volatile here; storage must keep it across power
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      otp_q  <= 1'b0;
      lock_q <= 1'b0;
      srp_q  <= 1'b0;
      bp_q   <= 4'h0;
    end else if (f_end) begin
      unique case (op_q)
        OP_OTP: begin
          if (cnt_q == BITS_CMD && !busy_i) begin
            otp_q <= 1'b1;
          end
        end
        OP_WRITE_DISABLE_COMMAND: begin
          if (cnt_q == BITS_CMD) begin
            otp_q <= 1'b0;
          end
        end
        OP_WRITE_STATUS_COMMAND: begin
          if (cnt_q == BITS_WR && !busy_i) begin
            if (otp_q) begin
              lock_q <= 1'b1;
            end else begin
              srp_q <= wd_q[ST_PROT];
              bp_q  <= wd_q[ST_BP_HI:ST_BP_LO];
            end
          end
        end
        default: ;
      endcase
    end
  end
  assign otp_mode_o = otp_q;
  assign otp_lock_o = lock_q;
  assign rd_addr_o  = addr_m;
  assign rd_otp_o   = otp_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      op_valid_o <= 1'b0;
      op_kind_o  <= OK_PROG;
      op_otp_o   <= 1'b0;
      op_addr_o  <= 32'h0000_0000;
      op_data_o  <= 8'h00;
    end else begin
      op_valid_o <= 1'b0;
      if (data_byte && (otp_q ? otp_ok : arr_ok)) begin
        op_valid_o <= 1'b1;
        op_kind_o  <= OK_PROG;
        op_otp_o   <= otp_q;
        op_addr_o  <= addr_m;
        op_data_o  <= byte_in;
      end else if (f_end && is_erase && erase_ok) begin
        op_valid_o <= 1'b1;
        op_kind_o  <= kind;
        op_otp_o   <= otp_q;
        op_addr_o  <= addr_m;
      end
    end
  end
endmodule // osf_flash_dev

// ### test/osf_link_sva.sv
/*
  Checker on the serial link between the flash end and the host end.
  Assumes the link clock is far slower than clock_i.
*/
`timescale 1ns/1ns
module osf_link_sva
  import osf_pkg::*;
(
  input logic clock_i,
  input logic resetn_i,
  input logic sel_n,
  input logic sclk,
  input logic sdi,
  input logic sdo,
  input logic sdo_oe
);
  logic       sclk_q;
  logic [7:0] rise_q;
  logic [7:0] opc_q;
  logic [3:0] age_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end
  // Rises in frame, saturating
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) rise_q <= 8'h00;
    else if (sel_n) rise_q <= 8'h00;
    else if (sclk && !sclk_q && rise_q != 8'hFF) rise_q <= rise_q + 8'h01;
  end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) opc_q <= 8'h00;
    else if (!sel_n && sclk && !sclk_q && rise_q < 8'h08) opc_q <= {opc_q[6:0], sdi};
  end
  // Cycles since last falling link edge
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) age_q <= 4'hF;
    else if (sclk_q && !sclk) age_q <= 4'h0;
    else if (age_q != 4'hF) age_q <= age_q + 4'h1;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  a_quiet_opcode: assert property (!sel_n && rise_q < 8'h08 |-> !sdo_oe)
    else $error("data out driven during opcode");
  a_param_start: assert property ($rose(sdo_oe) && opc_q == OP_SFDP |->
    rise_q == 8'h28 || rise_q == 8'h30)
    else $error("parameter output at wrong bit count");
  a_status_start: assert property ($rose(sdo_oe) && opc_q == OP_READ_STATUS_COMMAND |-> rise_q == 8'h08)
    else $error("status output at wrong bit count");
  a_oe_on_fall: assert property ($rose(sdo_oe) |-> !sclk && !sel_n && age_q <= 4'h8)
    else $error("output enabled away from falling edge");
  a_shift_on_fall: assert property (sdo_oe && $changed(sdo) |-> age_q <= 4'h8)
    else $error("data out changed away from falling edge");
  a_hold_high: assert property (sclk && sclk_q && sdo_oe && $past(sdo_oe) |->
    $stable(sdo))
    else $error("data out changed while link clock high");
  a_release_sel: assert property ($rose(sel_n) |-> ##[1:5] !sdo_oe)
    else $error("data out not released after deselect");
  a_idle_off: assert property (sel_n [*6] |-> !sdo_oe)
    else $error("data out driven while deselected");
endmodule // osf_link_sva

// ### test/test_otp_mode_and_sfdp_read.sv
/*
  Bench joining the flash end and the serial host over one link.
  Assumes storage answers with bits 15:8 of the read address.
*/
`timescale 1ns/1ns
module test_otp_mode_and_sfdp_read;
  import osf_pkg::*;
  logic        clock_i   = 1'b0;
  logic        resetn_i  = 1'b0;
  logic        busy_i    = 1'b0;
  logic        addr4_i   = 1'b0;
  logic [7:0]  rd_data_i = 8'h00;
  logic        valid     = 1'b0;
  logic [7:0]  op        = 8'h00;
  logic [31:0] addr      = 32'h0000_0000;
  logic [2:0]  nad       = 3'h0;
  logic        dum       = 1'b0;
  logic        wr        = 1'b0;
  logic [7:0]  wdata     = 8'h00;
  logic [7:0]  nrd       = 8'h00;
  logic        ready, done, refused, rvalid, ref_q, mode, lock, opv, opo, rotp;
  logic [7:0]  rdat, opd;
  logic [31:0] rda, opa;
  osf_op_type  opk;
  logic [7:0]  got[$];
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_ops      = 0;

  osf_spi_if link ();
  osf_flash_dev osf_flash_dev_inst (.clock_i(clock_i), .resetn_i(resetn_i), .bus(link.dev),
    .addr4_i(addr4_i), .busy_i(busy_i), .rd_data_i(rd_data_i), .rd_addr_o(rda),
    .rd_otp_o(rotp), .otp_mode_o(mode), .otp_lock_o(lock), .op_valid_o(opv),
    .op_kind_o(opk), .op_otp_o(opo), .op_addr_o(opa), .op_data_o(opd));
  osf_flash_host osf_flash_host_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .bus(link.host), .cmd_valid_i(valid), .cmd_ready_o(ready), .cmd_op_i(op),
    .cmd_addr_i(addr), .cmd_nad_i(nad), .cmd_dummy_i(dum), .cmd_wr_i(wr),
    .cmd_wdata_i(wdata), .cmd_nrd_i(nrd), .done_o(done), .refused_o(refused),
    .rd_valid_o(rvalid), .rd_data_o(rdat));
  osf_link_sva osf_link_sva_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .sel_n(link.sel_n), .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo),
    .sdo_oe(link.sdo_oe));

  initial begin
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    rd_data_i <= rda[15:8];
    if (opv === 1'b1) n_ops++;
  end

  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One frame: opcode, address bytes, dummy, write byte, read bytes
  task automatic run(input logic [7:0] o, input logic [31:0] a, input logic [2:0] na,
                     input logic d, input logic w, input logic [7:0] wd, input logic [7:0] nr);
    int k;
    got = {};
    op <= o;
    addr <= a;
    nad <= na;
    dum <= d;
    wr <= w;
    wdata <= wd;
    nrd <= nr;
    valid <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (ready !== 1'b1 && k < 100);
    if (ready !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
    valid <= 1'b0;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
      if (rvalid === 1'b1) got.push_back(rdat);
    end while (done !== 1'b1 && k < 20000);
    ref_q = refused;
    if (done !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task automatic sfdp(input logic [31:0] a, input logic [2:0] na, input logic [7:0] n,
                      input logic [127:0] e);
    run(OP_SFDP, a, na, 1'b1, 1'b0, 8'h00, n);
    check(32'(got.size()), 32'(n));
    foreach (got[i]) check(32'(got[i]), 32'(e[8*(n-1-i) +: 8]));
  endtask
  task automatic status(input logic [7:0] e);
    run(OP_READ_STATUS_COMMAND, 32'h0000_0000, 3'h0, 1'b0, 1'b0, 8'h00, 8'h01);
    check(32'(got.size() > 0 ? got[0] : 8'hXX), 32'(e));
  endtask
  task automatic opx(input int cnt, input osf_op_type k, input logic o, input logic [31:0] a);
    check(32'(n_ops), 32'(cnt));
    check({29'h0, opk, opo}, {29'h0, k, o});
    check(opa, a);
  endtask
  function automatic logic [31:0] cmd0(input logic [7:0] o);
    return {24'h00_0000, o};
  endfunction

  initial begin
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    sfdp(32'h0000_0000, 3'h3, 8'h10, 128'h5346_4450_0001_00FF_0000_0109_3000_00FF);
    sfdp(32'h0000_0030, 3'h3, 8'h09, 128'hE5_20B3_FFFF_FFFF_0044);
    addr4_i <= 1'b1;
    sfdp(32'h0000_00FE, 3'h4, 8'h04, 128'hFFFF_5346);
    addr4_i <= 1'b0;
    busy_i <= 1'b1;
    sfdp(32'h0000_0000, 3'h3, 8'h02, 128'hFFFF);
    busy_i <= 1'b0;
    $display("parameter reads done");
    run(OP_READ, 32'h0012_3456, 3'h3, 1'b0, 1'b0, 8'h00, 8'h01);
    check(32'(got[0]), 32'h0000_0034);
    run(OP_SE4K, 32'h0012_3456, 3'h3, 1'b0, 1'b0, 8'h00, 8'h00);
    opx(1, OK_SECTOR, 1'b0, 32'h0012_3456);
    run(OP_WRITE_STATUS_COMMAND, 32'h0000_0000, 3'h0, 1'b0, 1'b1, 8'h3C, 8'h00);
    run(OP_OTP, 32'h0000_0000, 3'h0, 1'b0, 1'b0, 8'h00, 8'h00);
    check({31'h0, ref_q}, 32'h0000_0001);
    check({31'h0, mode}, 32'h0000_0000);
    status(8'h3C);
    run(OP_WRITE_STATUS_COMMAND, 32'h0000_0000, 3'h0, 1'b0, 1'b1, 8'h00, 8'h00);
    run(OP_OTP, 32'h0000_0000, 3'h0, 1'b0, 1'b0, 8'h00, 8'h00);
    check({30'h0, ref_q, mode}, 32'h0000_0001);
    check({31'h0, rotp}, 32'h0000_0001);
    status(8'h00);
    $display("normal mode done");
    run(OP_SE4K, 32'h0012_3456, 3'h3, 1'b0, 1'b0, 8'h00, 8'h00);
    opx(2, OK_SECTOR, 1'b1, 32'h0000_0056);
    run(OP_BE64K, 32'h0000_0000, 3'h3, 1'b0, 1'b0, 8'h00, 8'h00);
    run(OP_CE, 32'h0000_0000, 3'h0, 1'b0, 1'b0, 8'h00, 8'h00);
    check(32'(n_ops), 32'h0000_0002);
    run(OP_PROG, 32'h0000_01FF, 3'h3, 1'b0, 1'b1, 8'hA5, 8'h00);
    opx(3, OK_PROG, 1'b1, 32'h0000_01FF);
    check(cmd0(opd), 32'h0000_00A5);
    run(OP_READ, 32'h0012_3456, 3'h3, 1'b0, 1'b0, 8'h00, 8'h01);
    check(32'(got[0]), 32'h0000_0000);
    run(OP_WRITE_STATUS_COMMAND, 32'h0000_0000, 3'h0, 1'b0, 1'b1, 8'hFF, 8'h00);
    check({31'h0, lock}, 32'h0000_0001);
    status(8'h80);
    run(OP_SE4K, 32'h0000_0010, 3'h3, 1'b0, 1'b0, 8'h00, 8'h00);
    run(OP_PROG, 32'h0000_0010, 3'h3, 1'b0, 1'b1, 8'h5A, 8'h00);
    check(32'(n_ops), 32'h0000_0003);
    $display("otp mode done");
    run(OP_WRITE_DISABLE_COMMAND, 32'h0000_0000, 3'h0, 1'b0, 1'b0, 8'h00, 8'h00);
    check({31'h0, mode}, 32'h0000_0000);
    check({31'h0, rotp}, 32'h0000_0000);
    status(8'h00);
    $display("exit done");
    end_sim();
  end
endmodule // test_otp_mode_and_sfdp_read
